/* design/fpbl_pkg.sv */
`default_nettype none
// ==========================================
// Front panel button and indicator constants
package fpbl_pkg;

  // Time base
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned MS_PER_S   = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;

  // Button hold thresholds and filter, in ms
  localparam logic [13:0] T_SHORT_MS  = 14'h3e8;  // 1 s
  localparam logic [13:0] T_LONG_MS   = 14'hbb8;  // 3 s
  localparam logic [13:0] T_RESET_MS  = 14'h2710; // 10 s
  localparam logic [13:0] T_DEB_MS    = 14'h14;   // 20 ms

  // Sequencing times, in ms
  localparam logic [14:0] T_LAMP_MS   = 15'hbb8;  // Lamp test, 3 s
  localparam logic [14:0] T_START_MS  = 15'h1388; // Converter start, 5 s
  localparam logic [14:0] T_BOOT_MS   = 15'h7530; // Gateway boot, 30 s
  localparam logic [8:0]  T_HALF_MS   = 9'hfa;    // Flash half period, 250 ms

  // Beep counts at each hold threshold
  localparam logic [2:0] BEEPS_SHORT = 3'h1;
  localparam logic [2:0] BEEPS_LONG  = 3'h2;
  localparam logic [2:0] BEEPS_RESET = 3'h5;

  // Flash code of one indicator
  typedef enum logic [2:0]
  {
    CODE_DARK   = 3'h0,
    CODE_F1     = 3'h1,
    CODE_F2     = 3'h2,
    CODE_F3     = 3'h3,
    CODE_F4     = 3'h4,
    CODE_STEADY = 3'h7
  } fpbl_code_type;

  // Unit sequencing states
  typedef enum logic [3:0]
  {
    ST_LAMP  = 4'h1,
    ST_OFF   = 4'h2,
    ST_START = 4'h4,
    ST_ON    = 4'h8
  } fpbl_state_type;

  // Inverter fault conditions
  typedef struct packed
  {
    logic low_batt;
    logic overload;
    logic thermal;
    logic other;
  } fpbl_fault_type;

  // Source port status
  typedef struct packed
  {
    logic present;
    logic connected;
    logic over_power;
    logic phase_err;
    logic other;
  } fpbl_src_type;

endpackage : fpbl_pkg
`default_nettype wire

/* design/fpbl_front_panel.sv */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [R1] Press under one second clears latched errors and silences buzzer, state kept.
// [R2] Release between one and three seconds toggles the unit on or off.
// [R3] One beep when the hold reaches one second.
// [R4] Release between three and ten seconds does nothing.
// [R5] Two beeps when the hold reaches three seconds.
// [R6] Hold beyond ten seconds resets all devices.
// [R7] Five beeps when the hold reaches ten seconds.
// [R8] Action is that of the last threshold passed at release.
// [R9] Disabled button gives no action.
// [R10] After power-up, beep and light all indicators a few seconds.
// [R11] After power-up unit is off, all enables low, red steady.
// [R12] Turn-on refused until initial configuration is done.
// [R13] Turn-on clears red, connects battery, enables ports; start takes five seconds.
// [R14] White: dark off, steady on, one flash standby, two waiting restart.
// [R15] Red: dark no error, steady off, flash one to four by fault.
// [R16] Source: dark, steady, one wait, two power, three phase, four other.
// [R17] Second source uses the same codes up to three flashes.
// [R18] Connectivity dark thirty seconds after power-up, then shows gateway ready.
// [R19] Buzzer repeats the red indicator's current flash sequence.
// [R20] Identification request blinks all indicators together.
// [R21] Flash groups repeat with equal on and off and a long pause.
// [R22] Button synchronised and debounced before hold timing.
module fpbl_front_panel
  import fpbl_pkg::*;
#(
  parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
)
(
  input  wire logic           clk_i,
  input  wire logic           arst_n_i,
  input  wire logic           button_i,
  input  wire logic           button_enable_i,
  input  wire logic           buzzer_enable_i,
  input  wire logic           config_done_i,
  input  wire logic           onoff_req_i,
  input  wire logic           identify_i,
  input  wire logic           gateway_ready_i,
  input  wire logic           standby_i,
  input  wire logic           wait_restart_i,
  input  wire fpbl_fault_type fault_i,
  input  wire fpbl_src_type   src_i,
  input  wire fpbl_src_type   src2_i,
  output logic                led_white_o,
  output logic                led_red_o,
  output logic                led_src_o,
  output logic                led_src2_o,
  output logic                led_conn_o,
  output logic                buzzer_o,
  output logic                unit_on_o,
  output logic                battery_connect_o,
  output logic                load_output_en_o,
  output logic                grid_genset_input_en_o,
  output logic                flexible_port_en_o,
  output logic                clear_errors_o,
  output logic                reset_all_o
);

  // ==========================================
  // Decoding helpers

  // Lit state of a code at a group slot
  function automatic logic fpbl_flash(input fpbl_code_type code, input logic [3:0] slot);
    logic lit;
    lit = 1'b0;
    if (code == CODE_STEADY)
      lit = 1'b1;
    else if (code != CODE_DARK)
      lit = (slot[3:1] < code) && !slot[0]; // R21
    return lit;
  endfunction

  // Code of a source port
  function automatic fpbl_code_type fpbl_src_code(input fpbl_src_type s, input logic has_other);
    fpbl_code_type c;
    c = CODE_DARK;
    if (s.other && has_other)
      c = CODE_F4;
    else if (s.phase_err)
      c = CODE_F3;
    else if (s.over_power)
      c = CODE_F2;
    else if (s.connected)
      c = CODE_STEADY;
    else if (s.present)
      c = CODE_F1;
    return c;
  endfunction

  // ==========================================
  // Millisecond tick
  logic [15:0] pre_cnt;
  logic        ms_tick;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pre_cnt <= 16'h0;
      ms_tick <= 1'b0;
    end
    else if (pre_cnt == 16'(CYC_PER_MS_P - 1))
    begin
      pre_cnt <= 16'h0;
      ms_tick <= 1'b1;
    end
    else
    begin
      pre_cnt <= pre_cnt + 16'h1;
      ms_tick <= 1'b0;
    end
  end

  // ==========================================
  // Button conditioning
  logic        btn_meta;
  logic        btn_sync;
  logic        btn_deb;
  logic        btn_deb_d;
  logic [13:0] deb_ms;

  // Two-stage synchroniser
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      btn_meta <= 1'b0;
      btn_sync <= 1'b0;
    end
    else
    begin
      btn_meta <= button_i; // R22
      btn_sync <= btn_meta;
    end
  end

  // Accept a level only after it stays stable
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      btn_deb   <= 1'b0;
      btn_deb_d <= 1'b0;
      deb_ms    <= 14'h0;
    end
    else
    begin
      btn_deb_d <= btn_deb;
      if (btn_sync == btn_deb)
        deb_ms <= 14'h0;
      else if (ms_tick)
      begin
        if (deb_ms == T_DEB_MS - 14'h1)
        begin
          btn_deb <= btn_sync; // R22
          deb_ms  <= 14'h0;
        end
        else
          deb_ms <= deb_ms + 14'h1;
      end
    end
  end

  // ==========================================
  // Hold timing and release action
  logic [13:0] hold_ms;
  logic        released;
  logic        press_clear;
  logic        press_toggle;
  logic        press_reset;

  assign released     = btn_deb_d && !btn_deb && button_enable_i; // R9
  assign press_clear  = released && (hold_ms < T_SHORT_MS); // R1 R8
  assign press_toggle = released && (hold_ms >= T_SHORT_MS) && (hold_ms < T_LONG_MS); // R2 R4
  assign press_reset  = released && (hold_ms >= T_RESET_MS); // R6 R8

  // Saturating hold counter
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      hold_ms <= 14'h0;
    else if (!btn_deb)
    begin
      if (!btn_deb_d)
        hold_ms <= 14'h0;
    end
    else if (ms_tick && hold_ms < T_RESET_MS)
      hold_ms <= hold_ms + 14'h1;
  end

  // Action pulses
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      clear_errors_o <= 1'b0;
      reset_all_o    <= 1'b0;
    end
    else
    begin
      clear_errors_o <= press_clear; // R1
      reset_all_o    <= press_reset; // R6
    end
  end

  // ==========================================
  // Feedback beep sequencer
  logic       thr_hit;
  logic [2:0] thr_beeps;
  logic [2:0] beep_left;
  logic       beep_on;
  logic [8:0] beep_ms;

  assign thr_hit = btn_deb && button_enable_i && ms_tick &&
                   (hold_ms == T_SHORT_MS - 14'h1 || hold_ms == T_LONG_MS - 14'h1 ||
                    hold_ms == T_RESET_MS - 14'h1);
  assign thr_beeps = (hold_ms == T_SHORT_MS - 14'h1) ? BEEPS_SHORT : // R3
                     (hold_ms == T_LONG_MS - 14'h1)  ? BEEPS_LONG  : // R5
                                                       BEEPS_RESET;  // R7

  // Each beep is one half period on, one off
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      beep_left <= 3'h0;
      beep_on   <= 1'b0;
      beep_ms   <= 9'h0;
    end
    else if (thr_hit)
    begin
      beep_left <= thr_beeps;
      beep_on   <= 1'b1;
      beep_ms   <= 9'h0;
    end
    else if (beep_left != 3'h0 && ms_tick)
    begin
      if (beep_ms == T_HALF_MS - 9'h1)
      begin
        beep_ms <= 9'h0;
        beep_on <= !beep_on; // R5 R7
        if (beep_on)
          beep_left <= beep_left - 3'h1;
      end
      else
        beep_ms <= beep_ms + 9'h1;
    end
  end

  // ==========================================
  // Fault latching and buzzer silence
  fpbl_fault_type flt;
  logic           silenced;

  // A new fault wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flt      <= '0;
      silenced <= 1'b0;
    end
    else
    begin
      flt <= (press_clear ? fpbl_fault_type'(4'h0) : flt) | fault_i; // R1
      if ((fault_i & ~flt) != '0)
        silenced <= 1'b0;
      else if (press_clear)
        silenced <= 1'b1; // R1
    end
  end

  // ==========================================
  // Unit sequencing
  fpbl_state_type state;
  logic [14:0]    state_ms;
  logic           toggle_req;

  assign toggle_req = press_toggle || onoff_req_i;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state    <= ST_LAMP;
      state_ms <= 15'h0;
    end
    else
    begin
      if (ms_tick)
        state_ms <= state_ms + 15'h1;
      unique case (state)
        ST_LAMP:
          if (ms_tick && state_ms == T_LAMP_MS - 15'h1)
          begin
            state    <= ST_OFF; // R10 R11
            state_ms <= 15'h0;
          end
        ST_OFF:
          if (toggle_req && config_done_i) // R12
          begin
            state    <= ST_START; // R13
            state_ms <= 15'h0;
          end
        ST_START:
          if (toggle_req)
            state <= ST_OFF;
          else if (ms_tick && state_ms == T_START_MS - 15'h1)
            state <= ST_ON; // R13
        ST_ON:
          if (toggle_req)
            state <= ST_OFF; // R2
      endcase
    end
  end

  // ==========================================
  // Flash group slot and gateway boot timer
  logic [8:0]  half_ms;
  logic [3:0]  slot;
  logic [14:0] boot_ms;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      half_ms <= 9'h0;
      slot    <= 4'h0;
      boot_ms <= 15'h0;
    end
    else if (ms_tick)
    begin
      if (boot_ms != T_BOOT_MS)
        boot_ms <= boot_ms + 15'h1; // R18
      if (half_ms == T_HALF_MS - 9'h1)
      begin
        half_ms <= 9'h0;
        slot    <= slot + 4'h1; // R21
      end
      else
        half_ms <= half_ms + 9'h1;
    end
  end

  // ==========================================
  // Indicator codes
  fpbl_code_type white_code;
  fpbl_code_type red_code;
  fpbl_code_type fault_code;
  logic          powered;

  assign powered = (state == ST_START) || (state == ST_ON);
  assign fault_code = flt.low_batt ? CODE_F1 :
                      flt.overload ? CODE_F2 :
                      flt.thermal  ? CODE_F3 :
                      flt.other    ? CODE_F4 : CODE_DARK; // R15
  assign red_code   = powered ? fault_code : CODE_STEADY; // R11 R13 R15
  assign white_code = !powered       ? CODE_DARK :
                      wait_restart_i ? CODE_F2   :
                      standby_i      ? CODE_F1   : CODE_STEADY; // R14

  // Registered indicator and buzzer drive
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      led_white_o <= 1'b0;
      led_red_o   <= 1'b0;
      led_src_o   <= 1'b0;
      led_src2_o  <= 1'b0;
      led_conn_o  <= 1'b0;
      buzzer_o    <= 1'b0;
    end
    else if (state == ST_LAMP)
    begin
      led_white_o <= 1'b1; // R10
      led_red_o   <= 1'b1;
      led_src_o   <= 1'b1;
      led_src2_o  <= 1'b1;
      led_conn_o  <= 1'b1;
      buzzer_o    <= (state_ms < 15'(T_HALF_MS)); // R10
    end
    else if (identify_i)
    begin
      led_white_o <= slot[0]; // R20
      led_red_o   <= slot[0];
      led_src_o   <= slot[0];
      led_src2_o  <= slot[0];
      led_conn_o  <= slot[0];
      buzzer_o    <= beep_on;
    end
    else
    begin
      led_white_o <= fpbl_flash(white_code, slot); // R14
      led_red_o   <= fpbl_flash(red_code, slot); // R15
      led_src_o   <= powered && fpbl_flash(fpbl_src_code(src_i, 1'b1), slot); // R16
      led_src2_o  <= powered && fpbl_flash(fpbl_src_code(src2_i, 1'b0), slot); // R17
      led_conn_o  <= (boot_ms == T_BOOT_MS) && gateway_ready_i; // R18
      buzzer_o    <= beep_on || (buzzer_enable_i && !silenced && powered &&
                     fpbl_flash(fault_code, slot)); // R19
    end
  end

  // Registered enables, all low until turn-on
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      unit_on_o              <= 1'b0;
      battery_connect_o      <= 1'b0;
      load_output_en_o       <= 1'b0;
      grid_genset_input_en_o <= 1'b0;
      flexible_port_en_o     <= 1'b0;
    end
    else
    begin
      unit_on_o              <= (state == ST_ON); // R13
      battery_connect_o      <= powered; // R11 R13
      load_output_en_o       <= powered;
      grid_genset_input_en_o <= powered;
      flexible_port_en_o     <= powered;
    end
  end

endmodule // fpbl_front_panel
`default_nettype wire

/* dv/fpbl_front_panel_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port checker of the front panel
module fpbl_front_panel_asserts
  import fpbl_pkg::*;
#(
  parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic button_enable_i,
  input wire logic identify_i,
  input wire logic led_white_o,
  input wire logic led_red_o,
  input wire logic led_src_o,
  input wire logic led_src2_o,
  input wire logic led_conn_o,
  input wire logic buzzer_o,
  input wire logic unit_on_o,
  input wire logic battery_connect_o,
  input wire logic load_output_en_o,
  input wire logic grid_genset_input_en_o,
  input wire logic flexible_port_en_o,
  input wire logic clear_errors_o,
  input wire logic reset_all_o
);
  localparam int unsigned START_CYC = T_START_MS * CYC_PER_MS_P;
  localparam int unsigned SLACK_CYC = 2 * CYC_PER_MS_P;
  int unsigned            start_cnt;

  // Cycles spent in the start phase
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      start_cnt <= 0;
    else if (battery_connect_o && !unit_on_o)
      start_cnt <= start_cnt + 1;
    else
      start_cnt <= 0;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // ==========================================
  // Assertions
  a_enables_together: assert property (
    load_output_en_o == battery_connect_o && grid_genset_input_en_o == battery_connect_o
    && flexible_port_en_o == battery_connect_o) else $error("enables differ");
  a_on_needs_load: assert property (
    unit_on_o |-> load_output_en_o) else $error("on without load output");
  a_start_time: assert property (
    $rose(unit_on_o) |-> start_cnt >= START_CYC - SLACK_CYC
    && start_cnt <= START_CYC + SLACK_CYC) else $error("start time wrong");
  a_red_when_off: assert property (
    (!battery_connect_o && !identify_i && $past(arst_n_i)) [*6] |-> $past(led_red_o, 2))
    else $error("red dark while off");
  a_lamp_at_power: assert property (
    $past(arst_n_i) && !$past(arst_n_i, 2) |-> ##1 (led_white_o && led_red_o && led_src_o
    && led_src2_o && led_conn_o && buzzer_o)) else $error("lamp test missing");
  a_reset_pulse_once: assert property (
    reset_all_o |-> !clear_errors_o ##1 !reset_all_o) else $error("reset pulse wrong");
  a_clear_keeps_state: assert property (
    clear_errors_o |=> !clear_errors_o ##0 $stable(battery_connect_o) [*3])
    else $error("clear pulse wrong");
  a_disabled_quiet: assert property (
    !$past(button_enable_i) |-> !clear_errors_o && !reset_all_o)
    else $error("action while disabled");

  // Main scenarios reached
  c_turn_on: cover property ($rose(unit_on_o));
  c_reset_all: cover property (reset_all_o);
  c_clear: cover property (clear_errors_o);
endmodule // fpbl_front_panel_asserts
`default_nettype wire

/* dv/fpbl_operator.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Operator at the push button
module fpbl_operator
#(
  parameter int unsigned CYC_PER_MS_P = 4
)
(
  input  wire logic clk_i,
  output logic      button_o
);
  initial button_o = 1'b0;

  // Contact chatter, odd count so the level flips
  task automatic chatter();
    repeat (3) @(negedge clk_i) button_o = ~button_o;
  endtask

  // One press held for hms milliseconds
  task automatic press(input int unsigned hms);
    chatter();
    repeat (hms * CYC_PER_MS_P) @(negedge clk_i);
    chatter();
  endtask
endmodule // fpbl_operator
`default_nettype wire

/* dv/tb_fpbl_front_panel.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Front panel bench
module tb_fpbl_front_panel
  import fpbl_pkg::*;
;
  localparam int unsigned M = 2;
  logic clk_i, arst_n_i, button_i, button_enable_i, buzzer_enable_i, config_done_i;
  logic onoff_req_i, identify_i, gateway_ready_i, standby_i, wait_restart_i;
  fpbl_fault_type fault_i;
  fpbl_src_type   src_i, src2_i;
  logic led_white_o, led_red_o, led_src_o, led_src2_o, led_conn_o, buzzer_o, unit_on_o;
  logic battery_connect_o, load_output_en_o, grid_genset_input_en_o, flexible_port_en_o;
  logic clear_errors_o, reset_all_o, buz_q, red_q, s2_q, src_q, wht_q;
  int unsigned n_src, n_wht;
  int unsigned err_count, samples_checked, n_clr, n_rst, n_beep, n_red, n_s2, n_neq, ms, k;
  integer seed;

  fpbl_front_panel #(.CYC_PER_MS_P(M)) u_fpbl_front_panel (.clk_i, .arst_n_i, .button_i,
    .button_enable_i, .buzzer_enable_i, .config_done_i, .onoff_req_i, .identify_i,
    .gateway_ready_i, .standby_i, .wait_restart_i, .fault_i, .src_i, .src2_i, .led_white_o,
    .led_red_o, .led_src_o, .led_src2_o, .led_conn_o, .buzzer_o, .unit_on_o,
    .battery_connect_o, .load_output_en_o, .grid_genset_input_en_o, .flexible_port_en_o,
    .clear_errors_o, .reset_all_o);
  fpbl_operator #(.CYC_PER_MS_P(M)) u_fpbl_operator (.clk_i(clk_i), .button_o(button_i));

  // Clock of 40 ns
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Event counters on the outputs
  always @(posedge clk_i)
  begin
    n_clr += (clear_errors_o === 1'b1);
    n_rst += (reset_all_o === 1'b1);
    n_beep += (buzzer_o === 1'b1 && buz_q !== 1'b1);
    n_red += (led_red_o === 1'b1 && red_q !== 1'b1);
    n_s2 += (led_src2_o === 1'b1 && s2_q !== 1'b1);
    n_src += (led_src_o === 1'b1 && src_q !== 1'b1);
    n_wht += (led_white_o === 1'b1 && wht_q !== 1'b1);
    n_neq += (identify_i && !({led_white_o, led_red_o, led_src_o, led_src2_o, led_conn_o}
      inside {5'h00, 5'h1f}));
    buz_q = buzzer_o;
    red_q = led_red_o;
    s2_q = led_src2_o;
    src_q = led_src_o;
    wht_q = led_white_o;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic wait_ms(input int unsigned wms);
    repeat (wms * M) @(negedge clk_i);
  endtask

  // Press, then let the feedback finish
  task automatic hold(input int unsigned hms, input int unsigned tail);
    n_clr = 0;
    n_rst = 0;
    n_beep = 0;
    u_fpbl_operator.press(hms);
    wait_ms(tail);
  endtask

  // Feedback beeps expected for a hold time, every threshold passed adds its group
  function automatic logic [7:0] beeps_for(input int unsigned hms);
    logic [7:0] n;
    n = 8'h00;
    if (hms >= T_SHORT_MS)
      n = n + 8'(BEEPS_SHORT);
    if (hms >= T_LONG_MS)
      n = n + 8'(BEEPS_LONG);
    if (hms >= T_RESET_MS)
      n = n + 8'(BEEPS_RESET);
    return n;
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog over the whole run
  initial
  begin
    repeat (40000 * M) @(posedge clk_i);
    err_count++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    seed = 32'hac1e;
    {arst_n_i, button_enable_i, buzzer_enable_i, config_done_i, onoff_req_i} = 5'h08;
    {identify_i, gateway_ready_i, standby_i, wait_restart_i} = 4'h4;
    {fault_i, src_i, src2_i} = '0;
    repeat (10) @(negedge clk_i);
    arst_n_i = 1'b1;
    wait_ms(100);
    chk({led_white_o, led_red_o, led_src_o, led_src2_o, led_conn_o, buzzer_o}, 8'h3f);
    wait_ms(T_LAMP_MS);
    chk({led_red_o, led_white_o, led_conn_o, battery_connect_o, unit_on_o}, 8'h10);
    onoff_req_i = 1'b1;
    @(negedge clk_i) onoff_req_i = 1'b0;
    wait_ms(200);
    chk(battery_connect_o, 1'b0);
    config_done_i = 1'b1;
    button_enable_i = 1'b0;
    hold(1500, 300);
    chk({n_beep[3:0], battery_connect_o}, 8'h00);
    $display("power-up tests done");
    button_enable_i = 1'b1;
    ms = 1100 + $unsigned($random(seed)) % 1700;
    hold(ms, 600);
    chk(8'(n_beep), beeps_for(ms));
    chk({battery_connect_o, led_red_o, n_clr != 0}, 8'h04);
    ms = 3800 + $unsigned($random(seed)) % 800;
    hold(ms, 700);
    chk(8'(n_beep), beeps_for(ms));
    chk({battery_connect_o, unit_on_o, led_white_o, n_clr != 0, n_rst != 0}, 8'h1c);
    $display("toggle tests done");
    k = $unsigned($random(seed)) % 4;
    fault_i = fpbl_fault_type'(4'h8 >> k);
    {buzzer_enable_i, src_i, src2_i} = 11'h634;
    wait_restart_i = 1'b1;
    wait_ms(100);
    fault_i = '0;
    {n_red, n_beep, n_s2, n_src, n_wht} = '0;
    wait_ms(16 * T_HALF_MS);
    chk(8'(n_red), 8'(k + 1));
    chk(8'(n_beep), 8'(k + 1));
    chk({n_src[3:0], n_s2[3:0]}, 8'h42);
    chk(8'(n_wht), 8'h02);
    wait_restart_i = 1'b0;
    identify_i = 1'b1;
    wait_ms(20);
    {n_neq, n_red} = '0;
    wait_ms(1000);
    chk({n_neq[3:0], n_red[3:0]}, 8'h02);
    identify_i = 1'b0;
    $display("indicator tests done");
    ms = 100 + $unsigned($random(seed)) % 700;
    hold(ms, 200);
    chk({n_clr != 0, n_rst != 0, battery_connect_o}, 8'h05);
    {n_red, n_beep} = '0;
    wait_ms(1000);
    chk({n_red[3:0], n_beep[3:0]}, 8'h00);
    ms = 10300 + $unsigned($random(seed)) % 300;
    hold(ms, 2600);
    chk(8'(n_beep), beeps_for(ms));
    chk({n_rst != 0, n_clr != 0}, 8'h02);
    wait_ms(1000);
    chk(led_conn_o, 1'b1);
    $display("button action tests done");
    end_sim();
  end
endmodule // tb_fpbl_front_panel

bind fpbl_front_panel fpbl_front_panel_asserts #(.CYC_PER_MS_P(CYC_PER_MS_P)) u_asserts (
  .clk_i, .arst_n_i, .button_enable_i, .identify_i, .led_white_o, .led_red_o, .led_src_o,
  .led_src2_o, .led_conn_o, .buzzer_o, .unit_on_o, .battery_connect_o, .load_output_en_o,
  .grid_genset_input_en_o, .flexible_port_en_o, .clear_errors_o, .reset_all_o);
`default_nettype wire
